// >>> core/crr_clock_reset.sv
/*
 * Core clock-ratio and reset-state control. Straps are caught once after reset,
 * decoded to a multiplier, and a core tick stream is issued at n ticks per local
 * clock period. Reset holds execution idle and all pads undriven.
 * Assumes the local clock input is slow enough (>= 6 block cycles per period)
 * and that straps and pins are synchronous to clk, except asyncIn and rst_n.
 */
//  Contract
//  - core ticks n per local clock period
//  - reset gives known state, execution idle
//  - all outputs undriven during reset
//  - asynchronous inputs and reset get synchronisers
//  - inputs recognised only after minimum width
`timescale 1ns/1ns
module crr_clock_reset #(
    parameter int AW = 4,           // asynchronous inputs
    parameter int PW = 8            // driven pads
) (
    input  wire logic                        clk,               // block clock, 250 MHz
    input  wire logic                        rst_n,             // async reset, active low
    input  wire logic                        local_clock_in,    // local clock, sampled
    input  wire logic [crr_pkg::STRAP_W-1:0] core_ratio_strap,  // ratio strap
    input  wire logic                        sysclk_freq_strap, // must be one
    input  wire logic [AW-1:0]               asyncIn,           // asynchronous inputs
    input  wire logic [PW-1:0]               padData,           // pad values from core
    input  wire logic [PW-1:0]               padEn,             // pad drive requests
    output logic                             coreTick,          // one core instruction cycle
    output logic                             localTick,         // local clock rising edge
    output logic [crr_pkg::HALF_W-1:0]       ratioHalves,       // multiplier times two
    output logic                             strapFault,        // reserved code or bad strap
    output logic                             execIdle,          // execution held idle
    output logic [AW-1:0]                    syncOut,           // qualified async inputs
    output logic [PW-1:0]                    padOut,            // pad output value
    output logic [PW-1:0]                    padOe              // pad output enable
);
    import crr_pkg::*;

    // =====================================================================
    // reset release: asserts at once, releases after two edges
    logic rstMeta_ff;
    logic rstSyncN_ff;
    logic rstSyncN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff  <= 1'b0;
            rstSyncN_ff <= 1'b0;
        end else begin
            rstMeta_ff  <= 1'b1;
            rstSyncN_ff <= rstMeta_ff;
        end
    end

    assign rstSyncN = rstSyncN_ff;

    // =====================================================================
    // input synchroniser
    crr_sync_if #(.W(AW)) syncBus ();
    assign syncBus.raw = asyncIn;

    crr_sync #(.W(AW), .MIN_CYC(MIN_PULSE_CYC)) uSync (
        .clk      (clk),
        .rstSyncN (rstSyncN),
        .sif      (syncBus)
    );

    // =====================================================================
    // state, strap capture and status
    crr_state_e          state_ff;
    crr_state_e          nxt_state;
    logic [STRAP_W-1:0]  strapHeld_ff;
    logic [STRAP_W-1:0]  nxt_strapHeld;
    logic                freqHeld_ff;
    logic                nxt_freqHeld;
    logic [HALF_W-1:0]   ratio_ff;
    logic [HALF_W-1:0]   nxt_ratio;
    logic                fault_ff;
    logic                nxt_fault;
    logic                idle_ff;
    logic                nxt_idle;
    logic                run;

    assign run = (state_ff == ST_RUN);

    always_comb begin
        nxt_state     = state_ff;
        nxt_strapHeld = strapHeld_ff;
        nxt_freqHeld  = freqHeld_ff;
        nxt_ratio     = ratio_ff;
        nxt_fault     = fault_ff;
        unique case (state_ff)
            ST_RESET: begin
                nxt_state = ST_STRAP;
            end
            ST_STRAP: begin
                // straps are static, so one sample after release is enough
                nxt_strapHeld = core_ratio_strap;
                nxt_freqHeld  = sysclk_freq_strap;
                nxt_ratio     = crr_ratio_halves(core_ratio_strap);
                nxt_fault     = (core_ratio_strap == CODE_RSVD) || !sysclk_freq_strap;
                nxt_state     = ST_RUN;
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
        endcase
        nxt_idle = (nxt_state != ST_RUN);
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_ff     <= ST_RESET;
            strapHeld_ff <= CODE_R2;
            freqHeld_ff  <= 1'b1;
            ratio_ff     <= HALF_R2;
            fault_ff     <= 1'b0;
            idle_ff      <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            strapHeld_ff <= nxt_strapHeld;
            freqHeld_ff  <= nxt_freqHeld;
            ratio_ff     <= nxt_ratio;
            fault_ff     <= nxt_fault;
            idle_ff      <= nxt_idle;
        end
    end

    // =====================================================================
    // core tick generator: each local edge adds n in halves, a tick costs two,
    // so half ratios carry over and even out across two periods
    logic                localQ_ff;
    logic                localPrev_ff;
    logic                localEdge;
    logic [BUDGET_W-1:0] budget_ff;
    logic [BUDGET_W-1:0] nxt_budget;
    logic                tick_ff;
    logic                nxt_tick;
    logic                ltick_ff;
    logic                nxt_ltick;

    assign localEdge = localQ_ff && !localPrev_ff;

    always_comb begin
        nxt_tick   = run && (budget_ff >= TICK_COST);
        nxt_ltick  = run && localEdge;
        nxt_budget = budget_ff;
        if (nxt_tick) begin
            nxt_budget = budget_ff - TICK_COST;
        end
        if (run && localEdge) begin
            nxt_budget = nxt_budget + BUDGET_W'(ratio_ff);
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            localQ_ff    <= 1'b0;
            localPrev_ff <= 1'b0;
            budget_ff    <= '0;
            tick_ff      <= 1'b0;
            ltick_ff     <= 1'b0;
        end else begin
            localQ_ff    <= local_clock_in;
            localPrev_ff <= localQ_ff;
            budget_ff    <= nxt_budget;
            tick_ff      <= nxt_tick;
            ltick_ff     <= nxt_ltick;
        end
    end

    // =====================================================================
    // pads: enable only in run, so reset leaves every pad to its pull
    logic [PW-1:0] nxt_padOut;
    logic [PW-1:0] nxt_padOe;
    logic [PW-1:0] padOut_ff;
    logic [PW-1:0] padOe_ff;
    logic [AW-1:0] syncOut_ff;

    always_comb begin
        nxt_padOe  = run ? padEn : '0;
        nxt_padOut = run ? padData : '0;
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            padOut_ff  <= '0;
            padOe_ff   <= '0;
            syncOut_ff <= '0;
        end else begin
            padOut_ff  <= nxt_padOut;
            padOe_ff   <= nxt_padOe;
            syncOut_ff <= syncBus.clean;
        end
    end

    // rst_n reaches the pad enables through rstSyncN's async clear at once
    assign coreTick    = tick_ff;
    assign localTick   = ltick_ff;
    assign ratioHalves = ratio_ff;
    assign strapFault  = fault_ff;
    assign execIdle    = idle_ff;
    assign syncOut     = syncOut_ff;
    assign padOut      = padOut_ff;
    assign padOe       = padOe_ff;

    // =====================================================================
    // checks
    AST_RATIO_TWO_TICKS: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        (run && localEdge && budget_ff == '0 && ratio_ff == HALF_R2)
        |-> ##2 tick_ff ##1 tick_ff ##1 !tick_ff)
        else $error("ratio two did not give two core ticks");

    AST_DECODE_THREE: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        (run && strapHeld_ff == CODE_R3) |-> (ratio_ff == HALF_R3) && (fault_ff == !freqHeld_ff))
        else $error("code 010 did not decode to three");

    AST_RESERVED_CODE: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        (run && strapHeld_ff == CODE_RSVD) |-> (ratio_ff == HALF_R2) && fault_ff)
        else $error("reserved code not flagged");

    AST_FREQ_STRAP_LOW: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        (run && !freqHeld_ff) |-> fault_ff)
        else $error("low frequency strap not flagged");

    AST_IDLE_AFTER_RELEASE: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        $rose(rstSyncN) |-> idle_ff ##1 idle_ff ##1 !idle_ff)
        else $error("idle state not held for two cycles after release");

    AST_PADS_OFF_IDLE: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        idle_ff |-> (padOe_ff == '0) && (tick_ff == 1'b0))
        else $error("pad driven while idle");

    COV_HALF_RATIO: cover property (@(posedge clk) disable iff (!rstSyncN)
        run && ratio_ff == HALF_R2H && tick_ff);
    COV_RESERVED: cover property (@(posedge clk) disable iff (!rstSyncN)
        run && fault_ff);
    COV_PAD_DRIVE: cover property (@(posedge clk) disable iff (!rstSyncN)
        padOe_ff != '0);

endmodule

// >>> core/crr_pkg.sv
/*
 * Shared constants for the core clock-ratio and reset-state block: strap codes,
 * ratio figures in half steps, timing counts and the ratio decode function.
 * Assumes a 250 MHz block clock; all ratio arithmetic is in half-multiplier units.
 */
package crr_pkg;

    // =====================================================================
    // strap field and codes
    localparam int          STRAP_W   = 3;
    localparam logic [2:0]  CODE_R2   = 3'h0;
    localparam logic [2:0]  CODE_R2H  = 3'h1;
    localparam logic [2:0]  CODE_R3   = 3'h2;
    localparam logic [2:0]  CODE_R3H  = 3'h3;
    localparam logic [2:0]  CODE_R4   = 3'h4;
    localparam logic [2:0]  CODE_R5   = 3'h5;
    localparam logic [2:0]  CODE_R6   = 3'h6;
    localparam logic [2:0]  CODE_RSVD = 3'h7;

    // =====================================================================
    // multipliers counted in halves, so 2.5 becomes 5
    localparam int          HALF_W    = 4;
    localparam logic [3:0]  HALF_R2   = 4'h4;
    localparam logic [3:0]  HALF_R2H  = 4'h5;
    localparam logic [3:0]  HALF_R3   = 4'h6;
    localparam logic [3:0]  HALF_R3H  = 4'h7;
    localparam logic [3:0]  HALF_R4   = 4'h8;
    localparam logic [3:0]  HALF_R5   = 4'ha;
    localparam logic [3:0]  HALF_R6   = 4'hc;

    // =====================================================================
    // core tick budget
    localparam int          BUDGET_W  = 5;
    localparam logic [4:0]  TICK_COST = 5'h2;

    // =====================================================================
    // timing
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          MIN_PULSE_NS  = 8;
    localparam int          MIN_PULSE_RAW = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          MIN_PULSE_CYC = (MIN_PULSE_RAW < 1) ? 1 : MIN_PULSE_RAW;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_STRAP,
        ST_RUN
    } crr_state_e;

    // reserved code falls back to the default multiplier
    function automatic logic [3:0] crr_ratio_halves(input logic [2:0] code);
        logic [3:0] h;
        h = HALF_R2;
        unique case (code)
            CODE_R2:   h = HALF_R2;
            CODE_R2H:  h = HALF_R2H;
            CODE_R3:   h = HALF_R3;
            CODE_R3H:  h = HALF_R3H;
            CODE_R4:   h = HALF_R4;
            CODE_R5:   h = HALF_R5;
            CODE_R6:   h = HALF_R6;
            CODE_RSVD: h = HALF_R2;
        endcase
        return h;
    endfunction

endpackage

// >>> core/crr_sync_if.sv
/*
 * Carrier between the top and its input synchroniser: raw pins in, clean levels out.
 * Assumes both ends run on the same block clock.
 */
`timescale 1ns/1ns
interface crr_sync_if #(parameter int W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// >>> core/crr_sync.sv
/*
 * Two-flop synchroniser per bit followed by a pulse-width qualifier.
 * Assumes raw inputs may change at any time; a level counts only after it held
 * for MIN_CYC cycles behind the second flop.
 */
`timescale 1ns/1ns
module crr_sync #(
    parameter int W       = 4,
    parameter int MIN_CYC = crr_pkg::MIN_PULSE_CYC
) (
    input wire logic clk,           // block clock
    input wire logic rstSyncN,      // synchronised reset, active low
    crr_sync_if.sync sif            // raw in, qualified out
);
    import crr_pkg::*;

    localparam int CW = $clog2(MIN_CYC + 1);

    logic [W-1:0]  meta_ff;
    logic [W-1:0]  syncQ_ff;
    logic [W-1:0]  clean_ff;
    logic [W-1:0]  nxt_clean;
    logic [CW-1:0] cnt_ff  [W];
    logic [CW-1:0] nxt_cnt [W];

    // =====================================================================
    // qualifier: meta_ff feeds only syncQ_ff
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_cnt[i]   = '0;
            nxt_clean[i] = clean_ff[i];
            if (syncQ_ff[i] != clean_ff[i]) begin
                if (cnt_ff[i] == CW'(MIN_CYC - 1)) begin
                    nxt_clean[i] = syncQ_ff[i];
                end else begin
                    nxt_cnt[i] = cnt_ff[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            meta_ff  <= '0;
            syncQ_ff <= '0;
            clean_ff <= '0;
            for (int i = 0; i < W; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            meta_ff  <= sif.raw;
            syncQ_ff <= meta_ff;
            clean_ff <= nxt_clean;
            for (int i = 0; i < W; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end

    assign sif.clean = clean_ff;

    // =====================================================================
    // checks
    AST_SYNC_NOT_SAME_CYCLE: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        ($rose(syncQ_ff[0]) && !clean_ff[0]) |=> !clean_ff[0])
        else $error("qualified level rose one cycle behind synchroniser");

    AST_MIN_PULSE_HELD: assert property (
        @(posedge clk) disable iff (!rstSyncN)
        $rose(clean_ff[0]) |-> $past(syncQ_ff[0]) && $past(syncQ_ff[0], 2))
        else $error("input recognised before its minimum width");

    COV_CLEAN_RISE: cover property (@(posedge clk) disable iff (!rstSyncN) $rose(clean_ff[0]));

endmodule

// >>> tb/crr_board_model.sv
/*
 * Board-side model: local clock source and strap drivers for the clock-ratio block.
 * Assumes the bench clock is the one board oscillator, so every derived clock
 * shares its source; straps are re-driven while the device is in reset or while forceStrap is high.
 */
`timescale 1ns/1ns
module crr_board_model (
    input  wire logic       clk,               // board oscillator
    input  wire logic       rst_n,             // board reset, active low
    input  wire logic       go,                // start a burst of local periods
    input  wire logic [7:0] periods,           // local periods per burst
    input  wire logic       forceStrap,        // drive straps outside reset on purpose
    input  wire logic [2:0] strapReq,          // wanted ratio code
    input  wire logic       freqReq,           // wanted frequency strap level
    output logic            local_clock_in,    // local clock, still outside bursts
    output logic [2:0]      core_ratio_strap,  // ratio strap
    output logic            sysclk_freq_strap  // frequency strap
);
    logic [7:0] left  = 8'h00;
    logic [3:0] phase = 4'h0;

    // =====================================================================
    // straps
    // straps move under reset or while forceStrap is high, so the device sees them change while powered up only on forceStrap
    always_ff @(posedge clk) begin
        if (!rst_n || forceStrap) begin
            core_ratio_strap  <= strapReq;
            sysclk_freq_strap <= freqReq;
        end
    end

    // =====================================================================
    // local clock
    // divided from the bench clock itself, period 12 cycles
    always_ff @(posedge clk) begin
        if (go) begin
            left  <= periods;
            phase <= 4'h0;
        end else if (left != 8'h00) begin
            phase <= (phase == 4'hb) ? 4'h0 : phase + 4'h1;
            if (phase == 4'hb) begin
                left <= left - 8'h01;
            end
        end
    end

    // low outside bursts: a free-running clock would hide a miscount
    assign local_clock_in = (left != 8'h00) && (phase >= 4'h6);
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench for the clock-ratio and reset-state block.
 * Assumes the board model supplies local clock and straps; the bench drives
 * reset, asynchronous inputs and pad requests on rising edges.
 */
`timescale 1ns/1ns
module testbench;
    import crr_pkg::*;

    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       go = 1'b0;
    logic [7:0] periods = 8'h00;
    logic       forceStrap = 1'b0;
    logic [2:0] strapReq = 3'h0;
    logic       freqReq = 1'b1;
    logic       localClk;
    logic [2:0] ratioStrap;
    logic       freqStrap;
    logic [3:0] asyncIn = 4'h0;
    logic [7:0] padData = 8'h00;
    logic [7:0] padEn = 8'h00;
    logic       coreTick, localTick, strapFault, execIdle;
    logic [3:0] ratioHalves, syncOut;
    logic [7:0] padOut, padOe;
    int         bad_count = 0;
    int         checks = 0;
    int         tickCnt = 0;
    int         locCnt = 0;

    always #2 clk = ~clk;

    crr_board_model u_board (.clk(clk), .rst_n(rst_n), .go(go), .periods(periods),
        .forceStrap(forceStrap), .strapReq(strapReq), .freqReq(freqReq),
        .local_clock_in(localClk), .core_ratio_strap(ratioStrap),
        .sysclk_freq_strap(freqStrap));

    crr_clock_reset #(.AW(4), .PW(8)) u_dut (.clk(clk), .rst_n(rst_n),
        .local_clock_in(localClk), .core_ratio_strap(ratioStrap),
        .sysclk_freq_strap(freqStrap), .asyncIn(asyncIn), .padData(padData),
        .padEn(padEn), .coreTick(coreTick), .localTick(localTick),
        .ratioHalves(ratioHalves), .strapFault(strapFault), .execIdle(execIdle),
        .syncOut(syncOut), .padOut(padOut), .padOe(padOe));

    always @(posedge clk) begin
        if (coreTick === 1'b1) tickCnt++;
        if (localTick === 1'b1) locCnt++;
    end

    // =====================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // pads are requested during reset on purpose: they must stay undriven
    task automatic do_reset(input logic [2:0] code, input logic freq);
        @(posedge clk);
        rst_n    <= 1'b0;
        strapReq <= code;
        freqReq  <= freq;
        padEn    <= 8'hff;
        padData  <= 8'hff;
        repeat (8) @(posedge clk);
        #1 check(execIdle, 1'b1, "idle in reset");
        check(padOe, 8'h00, "pads enabled in reset");
        check(padOut, 8'h00, "pad value in reset");
        check(ratioHalves, 4'h4, "ratio in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        padEn <= 8'h00;
    endtask

    task automatic run_local(input logic [7:0] n);
        tickCnt = 0;
        locCnt  = 0;
        @(posedge clk);
        go      <= 1'b1;
        periods <= n;
        @(posedge clk);
        go <= 1'b0;
        repeat (12 * n + 16) @(posedge clk);
        #1;
    endtask

    // =====================================================================
    // scenarios
    task automatic t_ratio_all;
        logic [3:0] halves [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h4};
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0], 1'b1);
            #1 check(ratioHalves, halves[c], "decoded ratio");
            check(strapFault, (c == 7), "reserved code flag");
            check(execIdle, 1'b0, "running after reset");
            run_local(8'h04);
            check(tickCnt, halves[c] * 2, "core ticks in four periods");
            check(locCnt, 4, "local edges seen");
        end
    endtask

    task automatic t_strap_freeze;
        do_reset(3'h6, 1'b1);
        @(posedge clk);
        forceStrap <= 1'b1;
        strapReq   <= 3'h0;
        @(posedge clk);
        forceStrap <= 1'b0;
        run_local(8'h01);
        check(ratioHalves, 4'hc, "strap change ignored");
        check(tickCnt, 6, "ticks after strap change");
    endtask

    task automatic t_freq;
        do_reset(3'h4, 1'b0);
        #1 check(strapFault, 1'b1, "low frequency strap");
        check(ratioHalves, 4'h8, "ratio with bad freq strap");
    endtask

    task automatic t_async;
        @(posedge clk);
        asyncIn <= 4'h1;
        @(posedge clk);
        asyncIn <= 4'h0;
        repeat (8) @(posedge clk);
        #1 check(syncOut, 4'h0, "short pulse passed");
        @(posedge clk);
        asyncIn <= 4'h5;
        repeat (4) @(posedge clk);
        #1 check(syncOut, 4'h0, "sync too early");
        @(posedge clk);
        #1 check(syncOut, 4'h5, "sync level");
    endtask

    task automatic t_pads;
        @(posedge clk);
        padEn   <= 8'ha5;
        padData <= 8'h3c;
        @(posedge clk);
        #1 check(padOe, 8'ha5, "pad enables in run");
        check(padOut, 8'h3c, "pad value in run");
        @(posedge clk);
        rst_n <= 1'b0;
        #1 check(padOe, 8'h00, "pads undriven at reset");
        check(padOut, 8'h00, "pad value at reset");
        check(execIdle, 1'b1, "idle at mid-run reset");
        do_reset(3'h0, 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        t_ratio_all();
        t_strap_freeze();
        t_freq();
        t_async();
        t_pads();
        end_sim();
    end

    // whole run is about 760 cycles
    initial begin
        #(4 * 20000);
        bad_count++;
        end_sim();
    end
endmodule
